// ---- sofc_pkg.sv ----
package sofc_pkg;
  localparam int NOUT = 24;
  localparam int NCH = 16;
  localparam int BANK_W = 8;
  localparam int AW = 10;
  localparam int CLK_HZ = 20_000_000;
  localparam int US_CYC = CLK_HZ / 1_000_000;
  localparam int MS_PER_S = 1000;
  localparam int LOSS_MS = 100;
  localparam int RX_ALARM_MS = 1000;
  localparam int AUTO_MAX_US = 20000;
  localparam int GROUP_SLOT_US = 2500;
  localparam int PCT_FULL = 100;
  localparam logic [11:0] NEUTRAL_US = 12'h5DC;
  localparam logic signed [7:0] TEMP_LIMIT_C = 8'sh50;
  // Global register byte addresses
  localparam logic [AW-1:0] A_CTRL = 10'h000;
  localparam logic [AW-1:0] A_ALMEN = 10'h004;
  localparam logic [AW-1:0] A_VTH = 10'h008;
  localparam logic [AW-1:0] A_ITH = 10'h00C;
  localparam logic [AW-1:0] A_CMD = 10'h010;
  localparam logic [AW-1:0] A_STAT = 10'h014;
  localparam logic [AW-1:0] A_OVL = 10'h018;
  localparam logic [AW-1:0] A_DIN = 10'h01C;
  localparam logic [AW-1:0] A_VMM1 = 10'h020;
  localparam logic [AW-1:0] A_VMM2 = 10'h024;
  localparam logic [AW-1:0] A_IT = 10'h028;
  localparam logic [AW-1:0] A_AVAIL = 10'h02C;
  // Global block and per-output tables, selected by address bits 9:8
  localparam logic [1:0] RG_GLB = 2'h0;
  localparam logic [1:0] RG_OCFG = 2'h1;
  localparam logic [1:0] RG_OLIM = 2'h2;
  localparam logic [1:0] RG_OTRM = 2'h3;
  // Control fields
  localparam int CT_FS = 0;
  localparam int CT_BANK = 1;
  localparam int CT_PER = 4;
  localparam int CT_DLY = 16;
  localparam logic [31:0] CTRL_RST = 32'h0064_0001;
  localparam int CM_ERASE = 0;
  localparam int CM_RESTORE = 1;
  // Output config fields
  localparam int OC_CH = 0;
  localparam int OC_REV = 4;
  localparam int OC_MODE = 5;
  localparam int OC_GRP = 7;
  localparam int OC_DF = 9;
  localparam int OC_DIN = 11;
  localparam int OC_SLEW = 12;
  localparam int OC_TH = 20;
  localparam int LM_HI = 0;
  localparam int LM_LO = 16;
  localparam int TR_TRIM = 0;
  localparam int TR_FS = 16;
  localparam logic [31:0] OLIM_RST = 32'h0E0C_01F4;
  localparam logic [1:0] MODE_HOLD = 2'h0;
  localparam logic [1:0] MODE_OFF = 2'h1;
  localparam logic [1:0] MODE_PRESET = 2'h2;
  localparam logic [1:0] DF_HIGH = 2'h1;
  localparam logic [1:0] DF_LOW = 2'h2;
  // Alarm bits, enables share the low four positions
  localparam int AL_TEMP = 0;
  localparam int AL_SHORT = 1;
  localparam int AL_RX1 = 2;
  localparam int AL_RX2 = 3;
  localparam int AL_V1 = 4;
  localparam int AL_V2 = 5;
  localparam int AL_CUR = 6;
  localparam int AL_CAP = 7;
  localparam logic [15:0] VMIN_INIT = 16'hFFFF;
  localparam logic [7:0] TMIN_INIT = 8'h7F;
  localparam logic [7:0] TMAX_INIT = 8'h80;
  typedef enum logic [1:0] {LS_OK = 2'h0, LS_DELAY = 2'h1, LS_FAIL = 2'h3} sofc_loss_t;
endpackage : sofc_pkg

// ---- sofc_out_map.sv ----
`timescale 1ns/1ps
module sofc_out_map (
  input wire logic signed [11:0] pos,
  input wire logic rev,
  input wire logic signed [11:0] trim,
  input wire logic signed [11:0] hi,
  input wire logic signed [11:0] lo,
  output logic signed [11:0] res
);
  import sofc_pkg::*;
  logic signed [13:0] s;
  always_comb begin
    s = (rev ? -14'(pos) : 14'(pos)) + 14'(trim);
    if (s > 14'(hi)) begin
      res = hi;
    end else if (s < 14'(lo)) begin
      res = lo;
    end else begin
      res = s[11:0];
    end
  end
endmodule : sofc_out_map

// ---- sofc_rx_mon.sv ----
`timescale 1ns/1ps
module sofc_rx_mon (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_ok,
  input wire logic ms_tick,
  input wire logic sec_tick,
  output logic lost,
  output logic alarm,
  output logic [6:0] pct
);
  import sofc_pkg::*;
  typedef struct packed {
    logic [10:0] gap_ms;
    logic [23:0] on_s;
    logic [23:0] tot_s;
    logic [31:0] rem;
    logic [2:0] step;
    logic busy;
    logic [6:0] q;
    logic [6:0] pct;
  } sofc_mon_t;
  sofc_mon_t r;
  sofc_mon_t n;
  logic [31:0] dsh;
  always_comb begin
    n = r;
    dsh = {8'h0, r.tot_s} << r.step;
    if (frame_ok) begin
      n.gap_ms = 11'h0;
    end else if (ms_tick && r.gap_ms != 11'h7FF) begin
      n.gap_ms = r.gap_ms + 11'h1;
    end
    // Serial divider: seven cycles per percentage, far below one second
    if (sec_tick) begin
      n.tot_s = r.tot_s + 24'h1;
      if (!lost) begin
        n.on_s = r.on_s + 24'h1;
      end
      n.rem = 32'(n.on_s) * 32'(PCT_FULL);
      n.step = 3'h6;
      n.q = 7'h0;
      n.busy = 1'b1;
    end else if (r.busy) begin
      if (r.rem >= dsh) begin
        n.rem = r.rem - dsh;
        n.q[r.step] = 1'b1;
      end
      if (r.step == 3'h0) begin
        n.busy = 1'b0;
        n.pct = n.q;
      end else begin
        n.step = r.step - 3'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.gap_ms <= 11'h7FF;
    end else begin
      r <= n;
    end
  end
  // No frame yet after reset counts as lost
  assign lost = r.gap_ms >= 11'(LOSS_MS);
  assign alarm = r.gap_ms > 11'(RX_ALARM_MS);
  assign pct = r.pct;
endmodule : sofc_rx_mon

// ---- sofc_top.sv ----
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module sofc_top #(
  parameter int US_PER_MS = 1000
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [sofc_pkg::AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RX1_WR,
  input wire logic [3:0] RX1_CH,
  input wire logic [11:0] RX1_POS,
  input wire logic RX1_FRM,
  input wire logic RX2_WR,
  input wire logic [3:0] RX2_CH,
  input wire logic [11:0] RX2_POS,
  input wire logic RX2_FRM,
  input wire logic [sofc_pkg::NOUT-1:0] SERVO_I,
  output logic [sofc_pkg::NOUT-1:0] SERVO_O,
  output logic [sofc_pkg::NOUT-1:0] SERVO_OE,
  output logic [sofc_pkg::NOUT-1:0] SERVO_PU,
  input wire logic [sofc_pkg::NOUT-1:0] OVL,
  input wire logic [7:0] TEMP,
  input wire logic [15:0] VBAT1,
  input wire logic [15:0] VBAT2,
  input wire logic [15:0] IBAT,
  input wire logic [15:0] CAP,
  output logic ALARM
);
  import sofc_pkg::*;
  typedef struct packed {
    logic [NOUT-1:0][31:0] ocfg;
    logic [NOUT-1:0][31:0] olim;
    logic [NOUT-1:0][31:0] otrm;
    logic [NCH-1:0][11:0] ch1;
    logic [NCH-1:0][11:0] ch2;
    logic [NOUT-1:0][11:0] cur;
    logic [NOUT-1:0] dout, pulse, slew_due, ovl_s1, ovl_s2, ovl_st, din_s1, din_s2;
    logic [31:0] ctrl, vth, ith, rdata;
    logic [3:0] alm_en;
    logic [7:0] alm, tmin, tmax;
    logic [15:0] v1min, v1max, v2min, v2max, imax, dly_ms;
    logic [4:0] us_cnt, idx;
    logic [9:0] ms_cnt, s_cnt;
    logic [14:0] frame_us;
    sofc_loss_t lstate;
  } sofc_state_t;
  sofc_state_t r;
  sofc_state_t n;
  logic us_tick, ms_tick, sec_tick;
  logic rx1_lost, rx2_lost, rx1_alm, rx2_alm, both_lost, loss_det, frm_act;
  logic [6:0] pct1, pct2;
  logic [31:0] c;
  logic [11:0] src, mapped, cur_sel, tgt, stepped, per, wid;
  logic [12:0] diff, mag;
  logic [7:0] slew;
  logic dlev;
  logic [14:0] st;
  logic [4:0] oi;
  logic ov;
  logic [NOUT-1:0] is_dio, is_in;

  assign us_tick = r.us_cnt == 5'(US_CYC - 1);
  assign ms_tick = us_tick && r.ms_cnt == 10'(US_PER_MS - 1);
  assign sec_tick = ms_tick && r.s_cnt == 10'(MS_PER_S - 1);
  assign both_lost = rx1_lost && rx2_lost;
  assign loss_det = r.lstate != LS_OK;
  assign frm_act = rx1_lost ? RX2_FRM : RX1_FRM;
  assign c = r.ocfg[r.idx];
  assign src = rx1_lost ? r.ch2[c[OC_CH +: 4]] : r.ch1[c[OC_CH +: 4]];
  assign cur_sel = r.cur[r.idx];
  assign tgt = r.otrm[r.idx][TR_FS +: 12];
  assign slew = c[OC_SLEW +: 8];
  assign dlev = ($signed(src) >= $signed(c[OC_TH +: 12])) ^ c[OC_REV];
  assign diff = 13'($signed(tgt)) - 13'($signed(cur_sel));
  assign mag = diff[12] ? 13'(-diff) : diff;
  assign stepped = (slew == 8'h0 || mag <= {5'h0, slew}) ? tgt :
    diff[12] ? cur_sel - {4'h0, slew} : cur_sel + {4'h0, slew};
  assign oi = ADDR[6:2];
  assign ov = !ADDR[7] && oi < 5'(NOUT);
  assign per = r.ctrl[CT_PER +: 12];

  sofc_out_map u_map (
    .pos(src),
    .rev(c[OC_REV]),
    .trim(r.otrm[r.idx][TR_TRIM +: 12]),
    .hi(r.olim[r.idx][LM_HI +: 12]),
    .lo(r.olim[r.idx][LM_LO +: 12]),
    .res(mapped)
  );
  sofc_rx_mon u_mon1 (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .frame_ok(RX1_FRM),
    .ms_tick(ms_tick),
    .sec_tick(sec_tick),
    .lost(rx1_lost),
    .alarm(rx1_alm),
    .pct(pct1)
  );
  sofc_rx_mon u_mon2 (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .frame_ok(RX2_FRM),
    .ms_tick(ms_tick),
    .sec_tick(sec_tick),
    .lost(rx2_lost),
    .alarm(rx2_alm),
    .pct(pct2)
  );

  for (genvar g = 0; g < NOUT; g++) begin : g_pin
    assign is_dio[g] = r.ctrl[CT_BANK + g / BANK_W];
    assign is_in[g] = is_dio[g] && r.ocfg[g][OC_DIN];
    assign SERVO_O[g] = is_dio[g] ? (r.dout[g] && !is_in[g]) : r.pulse[g];
    assign SERVO_OE[g] = !is_in[g];
    assign SERVO_PU[g] = is_in[g];
  end

  always_comb begin
    n = r;
    n.rdata = 32'h0;
    n.ovl_s1 = OVL;
    n.ovl_s2 = r.ovl_s1;
    n.din_s1 = SERVO_I;
    n.din_s2 = r.din_s1;
    n.ovl_st = r.ovl_st | r.ovl_s2;
    n.us_cnt = us_tick ? 5'h0 : r.us_cnt + 5'h1;
    if (us_tick) begin
      n.ms_cnt = ms_tick ? 10'h0 : r.ms_cnt + 10'h1;
    end
    if (ms_tick) begin
      n.s_cnt = sec_tick ? 10'h0 : r.s_cnt + 10'h1;
    end
    if (RX1_WR) begin
      n.ch1[RX1_CH] = RX1_POS;
    end
    if (RX2_WR) begin
      n.ch2[RX2_CH] = RX2_POS;
    end
    case (r.lstate)
      LS_OK: begin
        if (both_lost) begin
          n.lstate = LS_DELAY;
          n.dly_ms = 16'h0;
        end
      end
      LS_DELAY: begin
        if (!both_lost) begin
          n.lstate = LS_OK;
        end else if (r.dly_ms >= r.ctrl[CT_DLY +: 16]) begin
          n.lstate = LS_FAIL;
        end else if (ms_tick) begin
          n.dly_ms = r.dly_ms + 16'h1;
        end
      end
      LS_FAIL: begin
        if (!both_lost) begin
          n.lstate = LS_OK;
        end
      end
      default: n.lstate = LS_OK;
    endcase
    // Auto period restarts on each frame; a fallback period keeps pulses alive in loss
    if (per == 12'h0 ? (frm_act || (us_tick && r.frame_us >= 15'(AUTO_MAX_US - 1)))
        : (us_tick && r.frame_us >= {3'h0, per - 12'h1})) begin
      n.frame_us = 15'h0;
    end else if (us_tick) begin
      n.frame_us = r.frame_us + 15'h1;
    end
    // One output refreshed per cycle; 24 cycles per sweep is far below a frame
    n.idx = (r.idx == 5'(NOUT - 1)) ? 5'h0 : r.idx + 5'h1;
    n.slew_due[r.idx] = 1'b0;
    if (ms_tick) begin
      n.slew_due = '1;
    end
    if (!loss_det) begin
      n.cur[r.idx] = mapped;
      n.dout[r.idx] = dlev;
    end else if (r.lstate == LS_FAIL) begin
      if (c[OC_MODE +: 2] == MODE_PRESET && (slew == 8'h0 || r.slew_due[r.idx])) begin
        n.cur[r.idx] = stepped;
      end
      if (c[OC_DF +: 2] == DF_HIGH) begin
        n.dout[r.idx] = 1'b1;
      end else if (c[OC_DF +: 2] == DF_LOW) begin
        n.dout[r.idx] = 1'b0;
      end
    end
    for (int k = 0; k < NOUT; k++) begin
      wid = NEUTRAL_US + r.cur[k];
      st = 15'(r.ocfg[k][OC_GRP +: 2]) * 15'(GROUP_SLOT_US);
      n.pulse[k] = r.frame_us >= st && r.frame_us < st + {3'h0, wid} && !is_dio[k]
        && !(loss_det && !r.ctrl[CT_FS])
        && !(r.lstate == LS_FAIL && r.ocfg[k][OC_MODE +: 2] == MODE_OFF);
    end
    n.alm[AL_TEMP] = r.alm_en[AL_TEMP] && $signed(TEMP) > TEMP_LIMIT_C;
    n.alm[AL_SHORT] = r.alm_en[AL_SHORT] && |r.ovl_s2;
    n.alm[AL_RX1] = r.alm_en[AL_RX1] && rx1_alm;
    n.alm[AL_RX2] = r.alm_en[AL_RX2] && rx2_alm;
    n.alm[AL_V1] = r.vth[15:0] != 16'h0 && VBAT1 < r.vth[15:0];
    n.alm[AL_V2] = r.vth[31:16] != 16'h0 && VBAT2 < r.vth[31:16];
    n.alm[AL_CUR] = r.ith[15:0] != 16'h0 && IBAT > r.ith[15:0];
    n.alm[AL_CAP] = r.ith[31:16] != 16'h0 && CAP >= r.ith[31:16];
    if (WR && ADDR == A_CMD && WDATA[CM_ERASE]) begin
      n.v1min = VMIN_INIT;
      n.v2min = VMIN_INIT;
      n.v1max = 16'h0;
      n.v2max = 16'h0;
      n.imax = 16'h0;
      n.tmin = TMIN_INIT;
      n.tmax = TMAX_INIT;
    end else begin
      n.v1min = VBAT1 < r.v1min ? VBAT1 : r.v1min;
      n.v1max = VBAT1 > r.v1max ? VBAT1 : r.v1max;
      n.v2min = VBAT2 < r.v2min ? VBAT2 : r.v2min;
      n.v2max = VBAT2 > r.v2max ? VBAT2 : r.v2max;
      n.imax = IBAT > r.imax ? IBAT : r.imax;
      n.tmin = $signed(TEMP) < $signed(r.tmin) ? TEMP : r.tmin;
      n.tmax = $signed(TEMP) > $signed(r.tmax) ? TEMP : r.tmax;
    end
    if (WR) begin
      case (ADDR[9:8])
        RG_GLB: begin
          case (ADDR)
            A_CTRL: n.ctrl = WDATA;
            A_ALMEN: n.alm_en = WDATA[3:0];
            A_VTH: n.vth = WDATA;
            A_ITH: n.ith = WDATA;
            default: n.ctrl = n.ctrl;
          endcase
        end
        RG_OCFG: if (ov) n.ocfg[oi] = WDATA;
        RG_OLIM: if (ov) n.olim[oi] = WDATA;
        default: if (ov) n.otrm[oi] = WDATA;
      endcase
      if (ADDR == A_CMD && WDATA[CM_RESTORE]) begin
        n.ctrl = CTRL_RST;
        n.alm_en = 4'h0;
        n.vth = 32'h0;
        n.ith = 32'h0;
        n.ocfg = '0;
        n.otrm = '0;
        n.olim = {NOUT{OLIM_RST}};
      end
    end
    if (RD) begin
      case (ADDR[9:8])
        RG_GLB: begin
          case (ADDR)
            A_CTRL: n.rdata = r.ctrl;
            A_ALMEN: n.rdata = {28'h0, r.alm_en};
            A_VTH: n.rdata = r.vth;
            A_ITH: n.rdata = r.ith;
            A_STAT: n.rdata = {20'h0, r.alm, r.lstate == LS_FAIL, loss_det, rx2_lost, rx1_lost};
            A_OVL: n.rdata = {8'h0, r.ovl_st};
            A_DIN: n.rdata = {8'h0, r.din_s2 & is_in};
            A_VMM1: n.rdata = {r.v1max, r.v1min};
            A_VMM2: n.rdata = {r.v2max, r.v2min};
            A_IT: n.rdata = {r.tmax, r.tmin, r.imax};
            A_AVAIL: n.rdata = {17'h0, pct2, 1'b0, pct1};
            default: n.rdata = 32'h0;
          endcase
        end
        RG_OCFG: n.rdata = ov ? r.ocfg[oi] : 32'h0;
        RG_OLIM: n.rdata = ov ? r.olim[oi] : 32'h0;
        default: n.rdata = ov ? r.otrm[oi] : 32'h0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.olim <= {NOUT{OLIM_RST}};
      r.v1min <= VMIN_INIT;
      r.v2min <= VMIN_INIT;
      r.tmin <= TMIN_INIT;
      r.tmax <= TMAX_INIT;
      r.lstate <= LS_OK;
    end else begin
      r <= n;
    end
  end

  assign RDATA = r.rdata;
  assign ALARM = |r.alm;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  sequence s_loss_start;
    r.lstate == LS_OK ##0 both_lost;
  endsequence
  sequence s_fail_preset_idle;
    r.lstate == LS_FAIL ##0 c[OC_MODE +: 2] == MODE_PRESET ##0 slew != 8'h0 ##0 !r.slew_due[r.idx];
  endsequence

  a_fs_off_stop: assert property (loss_det && !r.ctrl[CT_FS] |=> r.pulse == '0)
    else $error("pulse seen during loss with fallback off");
  a_loss_enter: assert property (s_loss_start |=> r.lstate == LS_DELAY ##1 $stable(r.cur))
    else $error("loss delay not entered or positions moved");
  a_delay_keep: assert property (r.lstate == LS_DELAY |=> $stable(r.cur))
    else $error("positions changed during loss delay");
  a_hold_keep: assert property (r.lstate == LS_FAIL && c[OC_MODE +: 2] == MODE_HOLD
    |=> r.cur[$past(r.idx)] == $past(cur_sel))
    else $error("hold output changed in loss");
  a_off_quiet: assert property (r.lstate == LS_FAIL && c[OC_MODE +: 2] == MODE_OFF
    |=> !r.pulse[$past(r.idx)])
    else $error("off output pulsed in loss");
  a_slew_wait: assert property (s_fail_preset_idle |=> r.cur[$past(r.idx)] == $past(cur_sel))
    else $error("preset moved without slew step");
  a_map_load: assert property (!loss_det |=> r.cur[$past(r.idx)] == $past(mapped))
    else $error("output not loaded from mapped channel");
  a_clamp_hi: assert property (1'b1 |-> $signed(mapped) <= $signed(r.olim[r.idx][LM_HI +: 12]))
    else $error("deflection above upper limit");
  a_dout_level: assert property (!loss_det |=> r.dout[$past(r.idx)] == $past(dlev))
    else $error("digital level mismatch");
  a_ovl_sticky: assert property (1'b1 |=> ($past(r.ovl_st) & ~r.ovl_st) == 24'h0)
    else $error("overload flag dropped");
  a_temp_alm: assert property (r.alm_en[AL_TEMP] && $signed(TEMP) > TEMP_LIMIT_C |=> r.alm[AL_TEMP])
    else $error("temperature alarm missing");
endmodule : sofc_top

// ---- sofc_rx_model.sv ----
`timescale 1ns/1ps
module sofc_rx_model (
  input wire logic clk,
  input wire logic [23:0] pin_o,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pu,
  input wire logic [23:0] gnd,
  output logic [23:0] pin_i,
  output logic [1:0] wr = 2'h0,
  output logic [3:0] ch = 4'h0,
  output logic [11:0] pos = 12'h000,
  output logic [1:0] frm = 2'h0
);
  logic [1:0] on = 2'h0;
  int cnt = 0;
  // Undriven pin without pull-up reads inverted, so a stale level never passes
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~gnd & (pin_pu | ~pin_o));
  // Frames every 20 us from each receiver that is switched on
  always @(posedge clk) begin
    cnt <= (cnt == 399) ? 0 : cnt + 1;
    frm <= (cnt == 399) ? on : 2'h0;
  end
  task automatic put(input int r, input logic [3:0] c, input logic [11:0] p);
    @(posedge clk);
    wr[r-1] <= 1'b1;
    ch <= c;
    pos <= p;
    @(posedge clk);
    wr <= 2'h0;
    ch <= ~c;
    pos <= ~p;
  endtask : put
endmodule : sofc_rx_model

// ---- test_servo_output_failsafe_controller.sv ----
`timescale 1ns/1ps
module test_servo_output_failsafe_controller;
  import sofc_pkg::*;
  localparam int MS = 40;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [AW-1:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic [1:0] rwr;
  logic [1:0] rfrm;
  logic [3:0] rch;
  logic [11:0] rpos;
  logic [NOUT-1:0] s_i, s_o, s_oe, s_pu;
  logic [NOUT-1:0] gnd = 24'h0;
  logic [NOUT-1:0] ovl = 24'h0;
  logic [7:0] temp = 8'h19;
  logic [15:0] v1 = 16'h044C;
  logic [15:0] v2 = 16'h0;
  logic [15:0] ibat = 16'h0;
  logic [15:0] cap = 16'h0;
  logic alarm;
  int bad_count = 0;
  int check_count = 0;

  // Short ms keeps the 100 ms loss window at 4000 cycles
  sofc_top #(.US_PER_MS(2)) i_sofc_top (.CORE_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .RX1_WR(rwr[0]), .RX1_CH(rch), .RX1_POS(rpos),
    .RX1_FRM(rfrm[0]), .RX2_WR(rwr[1]), .RX2_CH(rch), .RX2_POS(rpos), .RX2_FRM(rfrm[1]),
    .SERVO_I(s_i), .SERVO_O(s_o), .SERVO_OE(s_oe), .SERVO_PU(s_pu), .OVL(ovl), .TEMP(temp),
    .VBAT1(v1), .VBAT2(v2), .IBAT(ibat), .CAP(cap), .ALARM(alarm));
  sofc_rx_model i_sofc_rx_model (.clk(clk), .pin_o(s_o), .pin_oe(s_oe), .pin_pu(s_pu), .gnd(gnd),
    .pin_i(s_i), .wr(rwr), .ch(rch), .pos(rpos), .frm(rfrm));

  initial forever #25 clk = ~clk;

  task automatic end_of_test;
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rdc(input string nm, input logic [AW-1:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check(nm, rdata & m, exp);
  endtask : rdc

  // Width of one pulse and the low gap after it; zero width when no pulse comes
  task automatic meas(input int p, output int w, output int lo, output logic [NOUT-1:0] snap);
    w = 0;
    lo = 0;
    while (s_o[p] !== 1'b0 && lo < 7000) begin @(posedge clk); lo++; end
    lo = 0;
    while (s_o[p] !== 1'b1 && lo < 7000) begin @(posedge clk); lo++; end
    snap = s_o;
    while (s_o[p] === 1'b1 && w < 7000) begin @(posedge clk); w++; end
    lo = 0;
    while (w > 0 && s_o[p] !== 1'b1 && lo < 7000) begin @(posedge clk); lo++; end
  endtask : meas

  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    end_of_test;
  end

  initial begin
    // Outputs 10-14: plain, reversed, trimmed, clamped high, clamped low
    logic [11:0] te [5] = '{12'h064, 12'hF9C, 12'h032, 12'h1F4, 12'hE0C};
    logic [NOUT-1:0] snap;
    int w, lo;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdc("ctrl", A_CTRL, ALL, CTRL_RST);
    rdc("olim", 10'h200, ALL, OLIM_RST);
    rdc("unmapped", 10'h030, ALL, 32'h0);
    @(posedge clk);
    #1 check("rdata", rdata, 32'h0);
    // Outputs 0-7 digital, period 300 us, fault delay 10 ms
    wr(A_CTRL, 32'h000A_12C3);
    wr(10'h100, 32'h0000_0002);
    wr(10'h104, 32'h0000_0012);
    wr(10'h108, 32'h0320_0003);
    wr(10'h10C, 32'h0000_0800);
    wr(10'h110, 32'h0000_0202);
    wr(10'h114, 32'h0000_0403);
    wr(10'h120, 32'h0000_0004);
    wr(10'h124, 32'h0000_0024);
    wr(10'h220, 32'h0A56_01F4);
    wr(10'h224, 32'h0A56_01F4);
    i_sofc_rx_model.on <= 2'h1;
    i_sofc_rx_model.put(1, 4'h2, 12'h064);
    i_sofc_rx_model.put(1, 4'h3, 12'h032);
    i_sofc_rx_model.put(1, 4'h4, 12'hA88);
    i_sofc_rx_model.put(2, 4'h2, 12'hF9C);
    i_sofc_rx_model.put(2, 4'h3, 12'h064);
    // Output 8 must keep a short pulse once the secondary takes over
    i_sofc_rx_model.put(2, 4'h4, 12'hA88);
    repeat (500) @(posedge clk);
    check("dout", 32'(s_o[5:0] & 6'h37), 32'h35);
    check("oe", 32'(s_oe[15:0]), 32'hFFF7);
    check("pu", 32'(s_pu[15:0]), 32'h0008);
    wr(10'h128, 32'h0000_0002);
    wr(10'h12C, 32'h0000_0012);
    wr(10'h330, 32'h0000_0032);
    wr(10'h134, 32'h0000_0005);
    wr(10'h138, 32'h0000_0006);
    // Output 15: preset 100, five units per ms
    wr(10'h13C, 32'h0000_5042);
    wr(10'h33C, 32'h0064_0000);
    i_sofc_rx_model.put(1, 4'h5, 12'h2BC);
    i_sofc_rx_model.put(1, 4'h6, 12'hD44);
    repeat (30) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      check("map", {20'h0, i_sofc_top.r.cur[10 + i]}, {20'h0, te[i]});
    end
    i_sofc_rx_model.put(1, 4'h3, 12'h031);
    repeat (100) @(posedge clk);
    check("dout2", 32'(s_o[2]), 32'h0);
    @(posedge clk);
    gnd <= 24'h000008;
    ovl <= 24'h000020;
    repeat (5) @(posedge clk);
    ovl <= 24'h0;
    rdc("din", A_DIN, 32'h8, 32'h0);
    @(posedge clk);
    gnd <= 24'h0;
    repeat (8) @(posedge clk);
    rdc("din", A_DIN, 32'h8, 32'h8);
    rdc("ovl", A_OVL, ALL, 32'h20);
    meas(8, w, lo, snap);
    check("width", 32'(w > 1990 && w < 2010), 32'h1);
    check("gap", 32'(lo > 3990 && lo < 4010), 32'h1);
    check("group", 32'(snap[9:8]), 32'h3);
    wr(A_ALMEN, 32'h1);
    wr(A_VTH, 32'h0000_03E8);
    wr(A_ITH, 32'h00C8_01F4);
    @(posedge clk);
    temp <= 8'h51;
    v1 <= 16'h0384;
    ibat <= 16'h0258;
    cap <= 16'h00C8;
    repeat (5) @(posedge clk);
    rdc("alarms", A_STAT, 32'hF10, 32'hD10);
    check("alarm", 32'(alarm), 32'h1);
    @(posedge clk);
    temp <= 8'h50;
    v1 <= 16'h044C;
    ibat <= 16'h01F4;
    cap <= 16'h00C7;
    repeat (5) @(posedge clk);
    rdc("alarms", A_STAT, 32'hF10, 32'h0);
    check("alarm", 32'(alarm), 32'h0);
    wr(A_ALMEN, 32'h0);
    temp <= 8'h5A;
    repeat (5) @(posedge clk);
    rdc("temp_off", A_STAT, 32'h10, 32'h0);
    rdc("vmm1", A_VMM1, ALL, 32'h044C_0384);
    wr(A_CMD, 32'h1);
    repeat (3) @(posedge clk);
    rdc("vmm1", A_VMM1, ALL, 32'h044C_044C);
    rdc("cmd", A_CMD, ALL, 32'h0);
    i_sofc_rx_model.on <= 2'h3;
    repeat (500) @(posedge clk);
    check("primary", 32'(s_o[0]), 32'h1);
    @(posedge clk iff rfrm[0]);
    i_sofc_rx_model.on <= 2'h2;
    repeat (100 * MS + 200) @(posedge clk);
    rdc("status", A_STAT, 32'hF, 32'h1);
    check("secondary", 32'(s_o[0]), 32'h0);
    @(posedge clk iff rfrm[1]);
    i_sofc_rx_model.on <= 2'h0;
    repeat (100 * MS - 100) @(posedge clk);
    rdc("status", A_STAT, 32'hF, 32'h1);
    repeat (200) @(posedge clk);
    rdc("status", A_STAT, 32'hF, 32'h7);
    check("delay", 32'(s_o[5:4]), 32'h2);
    check("fsdelay", {20'h0, i_sofc_top.r.cur[15]}, 32'h0000_0F9C);
    repeat (10 * MS + 100) @(posedge clk);
    rdc("status", A_STAT, 32'hF, 32'hF);
    check("slew", 32'($signed(i_sofc_top.r.cur[15]) > -100 &&
      $signed(i_sofc_top.r.cur[15]) < 100), 32'h1);
    check("dloss", 32'({s_o[5:4], s_o[0]}), 32'h2);
    meas(8, w, lo, snap);
    check("hold", 32'(w > 1990 && w < 2010), 32'h1);
    meas(9, w, lo, snap);
    check("off", 32'(w), 32'h0);
    check("preset", {20'h0, i_sofc_top.r.cur[15]}, 32'h0000_0064);
    @(posedge clk);
    i_sofc_rx_model.on <= 2'h1;
    repeat (500) @(posedge clk);
    rdc("status", A_STAT, 32'hF, 32'h2);
    wr(A_CTRL, 32'h000A_12C2);
    @(posedge clk iff rfrm[0]);
    i_sofc_rx_model.on <= 2'h0;
    repeat (100 * MS + 200) @(posedge clk);
    meas(8, w, lo, snap);
    check("nofs", 32'(w), 32'h0);
    end_of_test;
  end
endmodule : test_servo_output_failsafe_controller
